// ---- rtl/lvds_cfg_pkg.sv ----
// Purpose: constants and types of the transmitter output configuration bank
// Assumes: 8-bit registers reached over a two-wire serial port, 8-bit register addresses
// Notes: Contract list below
// Contract
// - Bit 7 of 0x1c makes the clock channel swing follow the even bank (0) or the odd bank (1).
// - Bit 6 of 0x1c makes the clock channel common-mode follow the even bank (0) or the odd bank (1).
// - Bit 5 of 0x1c sets the even-bank swing to 400 mV (0) or 250 mV (1).
// - Bit 4 of 0x1c sets the odd-bank swing to 400 mV (0) or 250 mV (1).
// - Bits 3:2 of 0x1c give the even-bank common-mode: 00 1.2 V, 01 1.0 V, 10 0.8 V, 11 unavailable; the code drives the 1.2 V level for 11.
// - Bits 1:0 of 0x1c give the odd-bank common-mode with the same coding; the code drives the 1.2 V level for 11.
// - Bits 4:0 of 0x1d disable even-bank channels E..A when set; bits 7:5 are reserved.
// - Bits 4:0 of 0x1e disable odd-bank channels E..A when set; bits 7:5 are reserved.
// - Mode 11 in bits 7:6 of 0x1f enables outputs while the clock-absent indication is high, lock ignored.
// - Mode 10 enables outputs after 1K pixel clocks and with the PLL strobes aligned to the reference.
// - Mode 01 enables outputs after 2K pixel clocks.
// - Mode 00 enables outputs after 1K pixel clocks.
// - Bit 5 of 0x1f sizes the wait counter at 1K (0) or 2K (1); bits 4:0 are reserved.
// - A host reads and writes the registers over the two-wire serial port with 8-bit addresses.
package lvds_cfg_pkg;
	localparam logic [7:0] ADDR_LEVEL = 8'h1c;
	localparam logic [7:0] ADDR_EVEN_DIS = 8'h1d;
	localparam logic [7:0] ADDR_ODD_DIS = 8'h1e;
	localparam logic [7:0] ADDR_AVAIL = 8'h1f;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] DIS_MASK = 8'h1f;
	localparam logic [7:0] AVAIL_MASK = 8'he0;
	localparam int CLK_SWING_SRC_BIT = 7;
	localparam int CLK_CM_SRC_BIT = 6;
	localparam int EVEN_SWING_BIT = 5;
	localparam int ODD_SWING_BIT = 4;
	localparam int EVEN_CM_LSB = 2;
	localparam int ODD_CM_LSB = 0;
	localparam int AVAIL_MODE_LSB = 6;
	localparam int WAIT_SIZE_BIT = 5;
	localparam int NUM_CHANNELS = 5;
	localparam logic [1:0] CM_1V2 = 2'h0;
	localparam logic [1:0] CM_NA = 2'h3;
	localparam int CNT_W = 12;
	localparam logic [CNT_W-1:0] CNT_1K = 12'h400;
	localparam logic [CNT_W-1:0] CNT_2K = 12'h800;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// serial slave address, value arbitrary
	localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h3a;

	typedef enum logic [1:0] {
		MODE_DEFAULT = 2'h0,
		MODE_2K = 2'h1,
		MODE_PLL = 2'h2,
		MODE_NOCLK = 2'h3
	} avail_mode_e;

	typedef struct packed {
		logic swing_low;
		logic [1:0] cm;
	} drive_s;

	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_wr_s;
endpackage

// ---- rtl/two_wire_slave.sv ----
// Purpose: two-wire serial slave giving byte writes and reads to a register bank
// Assumes: scl and sda_in synchronous to clk and slow against it
// Notes: register pointer auto-increments after each data byte
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave
	import lvds_cfg_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = SLAVE_ADDR_DEFAULT
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output reg_wr_s wr,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data
);
	typedef enum logic [2:0] {S_IDLE, S_DEV, S_REG, S_WR, S_ACK, S_RD, S_MACK} slv_state_e;
	slv_state_e st, next_st, after, next_after;
	logic [3:0] bits, next_bits;
	logic [7:0] shreg, next_shreg, ptr, next_ptr;
	logic scl_q, sda_q, next_oe;
	reg_wr_s next_wr;
	logic scl_rise, scl_fall, start, stop;

	assign scl_rise = scl & ~scl_q;
	assign scl_fall = ~scl & scl_q;
	assign start = scl & scl_q & sda_q & ~sda_in;
	assign stop = scl & scl_q & ~sda_q & sda_in;
	assign rd_addr = ptr;

	always_comb begin
		next_st = st;
		next_after = after;
		next_bits = bits;
		next_shreg = shreg;
		next_ptr = ptr;
		next_oe = sda_oe;
		next_wr = '{en: 1'b0, addr: ptr, data: shreg};
		if (start) begin
			next_st = S_DEV;
			next_bits = '0;
			next_oe = 1'b0;
		end else if (stop) begin
			next_st = S_IDLE;
			next_oe = 1'b0;
		end else begin
			unique case (st)
				S_IDLE: begin
				end
				S_DEV, S_REG, S_WR: begin
					if (scl_rise) begin
						next_shreg = {shreg[6:0], sda_in};
						next_bits = bits + 4'h1;
					end else if (scl_fall && bits == BYTE_BITS) begin
						next_bits = '0;
						next_oe = 1'b1;
						next_st = S_ACK;
						if (st == S_DEV) begin
							next_after = shreg[0] ? S_RD : S_REG;
							if (shreg[7:1] != DEV_ADDR) begin
								next_oe = 1'b0;
								next_st = S_IDLE;
							end
						end else if (st == S_REG) begin
							next_ptr = shreg;
							next_after = S_WR;
						end else begin
							next_wr.en = 1'b1;
							next_ptr = ptr + 8'h01;
							next_after = S_WR;
						end
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						next_st = after;
						next_oe = 1'b0;
						if (after == S_RD) begin
							next_shreg = rd_data;
							next_ptr = ptr + 8'h01;
							next_oe = ~rd_data[7];
							next_bits = '0;
						end
					end
				end
				S_RD: begin
					if (scl_fall) begin
						next_bits = bits + 4'h1;
						next_shreg = {shreg[6:0], 1'b0};
						if (bits == BYTE_BITS - 4'h1) begin
							next_oe = 1'b0;
							next_st = S_MACK;
						end else begin
							next_oe = ~shreg[6];
						end
					end
				end
				S_MACK: begin
					if (scl_rise) begin
						next_st = sda_in ? S_IDLE : S_ACK;
						next_after = S_RD;
					end
				end
				default: next_st = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st <= S_IDLE;
			after <= S_IDLE;
			bits <= '0;
			shreg <= '0;
			ptr <= '0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
			wr <= '0;
		end else if (ce) begin
			st <= next_st;
			after <= next_after;
			bits <= next_bits;
			shreg <= next_shreg;
			ptr <= next_ptr;
			scl_q <= scl;
			sda_q <= sda_in;
			sda_oe <= next_oe;
			sda_out <= 1'b0;
			wr <= next_wr;
		end
	end

	property p_write_acked;
		@(posedge clk) disable iff (!nrst)
		wr.en |-> sda_oe && st == S_ACK && after == S_WR;
	endproperty
	a_write_acked: assert property (p_write_acked) else $error("write strobe without ack");
endmodule
`default_nettype wire

// ---- rtl/lvds_tx_output_config.sv ----
// Purpose: output level, channel disable and output availability control of the transmitter
// Assumes: pixel clock tick, clock-absent and strobe alignment inputs synchronous to CLK
// Notes: CE freezes everything, power-down included
`timescale 1ns/1ps
`default_nettype none
module lvds_tx_output_config
	import lvds_cfg_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = SLAVE_ADDR_DEFAULT
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic CE,
	input wire logic POWER_DOWN_INPUT,
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic INPUT_PIXEL_CLOCK_TICK,
	input wire logic NO_CLK,
	input wire logic STROBES_ALIGNED,
	output logic [NUM_CHANNELS-1:0] EVEN_BANK_OUTPUTS_EN,
	output logic [NUM_CHANNELS-1:0] ODD_BANK_OUTPUTS_EN,
	output logic CLOCK_CHANNEL_EN,
	output drive_s EVEN_DRIVE,
	output drive_s ODD_DRIVE,
	output drive_s CLOCK_DRIVE,
	output logic OUTPUTS_AVAILABLE
);
	reg_wr_s wr;
	logic [7:0] rd_addr, rd_data;
	logic [7:0] level, even_dis, odd_dis, avail_ctl;
	logic [7:0] next_level, next_even_dis, next_odd_dis, next_avail_ctl;
	logic [CNT_W-1:0] cnt, next_cnt, target;
	logic next_avail, met;
	avail_mode_e mode;
	logic [NUM_CHANNELS-1:0] next_even_en, next_odd_en;
	drive_s next_even_drive, next_odd_drive, next_clock_drive;

	two_wire_slave #(
		.DEV_ADDR(DEV_ADDR)
	) u_slave (
		.clk(CLK),
		.nrst(NRST),
		.ce(CE),
		.scl(SCL),
		.sda_in(SDA_IN),
		.sda_out(SDA_OUT),
		.sda_oe(SDA_OE),
		.wr(wr),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	function automatic logic [1:0] cm_level(input logic [1:0] code);
		// the unavailable code falls back to the 1.2 V level
		return (code == CM_NA) ? CM_1V2 : code;
	endfunction

	always_comb begin
		case (rd_addr)
			ADDR_LEVEL: rd_data = level;
			ADDR_EVEN_DIS: rd_data = even_dis;
			ADDR_ODD_DIS: rd_data = odd_dis;
			ADDR_AVAIL: rd_data = avail_ctl;
			default: rd_data = REG_RESET;
		endcase
	end

	// register bank
	always_comb begin
		next_level = level;
		next_even_dis = even_dis;
		next_odd_dis = odd_dis;
		next_avail_ctl = avail_ctl;
		if (POWER_DOWN_INPUT) begin
			next_level = REG_RESET;
			next_even_dis = REG_RESET;
			next_odd_dis = REG_RESET;
			next_avail_ctl = REG_RESET;
		end else if (wr.en) begin
			case (wr.addr)
				ADDR_LEVEL: next_level = wr.data;
				ADDR_EVEN_DIS: next_even_dis = wr.data & DIS_MASK;
				ADDR_ODD_DIS: next_odd_dis = wr.data & DIS_MASK;
				ADDR_AVAIL: next_avail_ctl = wr.data & AVAIL_MASK;
				default: begin
				end
			endcase
		end
	end

	// output availability
	assign mode = avail_mode_e'(avail_ctl[AVAIL_MODE_LSB +: 2]);
	assign target = (mode == MODE_2K || avail_ctl[WAIT_SIZE_BIT]) ? CNT_2K : CNT_1K;
	assign met = next_cnt >= target;

	always_comb begin
		next_cnt = cnt;
		if (POWER_DOWN_INPUT || NO_CLK) begin
			next_cnt = '0;
		end else if (INPUT_PIXEL_CLOCK_TICK && cnt != CNT_2K) begin
			next_cnt = cnt + 12'h001;
		end
		next_avail = 1'b0;
		if (!POWER_DOWN_INPUT) begin
			unique case (mode)
				MODE_NOCLK: next_avail = NO_CLK;
				MODE_PLL: next_avail = met && STROBES_ALIGNED;
				MODE_2K: next_avail = met;
				MODE_DEFAULT: next_avail = met;
			endcase
		end
	end

	// drive levels
	always_comb begin
		next_even_drive.swing_low = next_level[EVEN_SWING_BIT];
		next_even_drive.cm = cm_level(next_level[EVEN_CM_LSB +: 2]);
		next_odd_drive.swing_low = next_level[ODD_SWING_BIT];
		next_odd_drive.cm = cm_level(next_level[ODD_CM_LSB +: 2]);
		next_clock_drive.swing_low = next_level[CLK_SWING_SRC_BIT] ? next_odd_drive.swing_low :
			next_even_drive.swing_low;
		next_clock_drive.cm = next_level[CLK_CM_SRC_BIT] ? next_odd_drive.cm : next_even_drive.cm;
	end

	for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_chan
		assign next_even_en[i] = next_avail & ~next_even_dis[i];
		assign next_odd_en[i] = next_avail & ~next_odd_dis[i];
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			level <= REG_RESET;
			even_dis <= REG_RESET;
			odd_dis <= REG_RESET;
			avail_ctl <= REG_RESET;
			cnt <= '0;
			OUTPUTS_AVAILABLE <= 1'b0;
			CLOCK_CHANNEL_EN <= 1'b0;
			EVEN_BANK_OUTPUTS_EN <= '0;
			ODD_BANK_OUTPUTS_EN <= '0;
			EVEN_DRIVE <= '0;
			ODD_DRIVE <= '0;
			CLOCK_DRIVE <= '0;
		end else if (CE) begin
			level <= next_level;
			even_dis <= next_even_dis;
			odd_dis <= next_odd_dis;
			avail_ctl <= next_avail_ctl;
			cnt <= next_cnt;
			OUTPUTS_AVAILABLE <= next_avail;
			CLOCK_CHANNEL_EN <= next_avail;
			EVEN_BANK_OUTPUTS_EN <= next_even_en;
			ODD_BANK_OUTPUTS_EN <= next_odd_en;
			EVEN_DRIVE <= next_even_drive;
			ODD_DRIVE <= next_odd_drive;
			CLOCK_DRIVE <= next_clock_drive;
		end
	end

	property p_clk_swing;
		@(posedge CLK) disable iff (!NRST)
		CLOCK_DRIVE.swing_low == (level[CLK_SWING_SRC_BIT] ? ODD_DRIVE.swing_low : EVEN_DRIVE.swing_low);
	endproperty
	a_clk_swing: assert property (p_clk_swing) else $error("clock swing source wrong");

	property p_clk_cm;
		@(posedge CLK) disable iff (!NRST)
		CLOCK_DRIVE.cm == (level[CLK_CM_SRC_BIT] ? ODD_DRIVE.cm : EVEN_DRIVE.cm);
	endproperty
	a_clk_cm: assert property (p_clk_cm) else $error("clock common-mode source wrong");

	property p_even_swing;
		@(posedge CLK) disable iff (!NRST)
		CE && wr.en && wr.addr == ADDR_LEVEL && !POWER_DOWN_INPUT
		|=> EVEN_DRIVE.swing_low == $past(wr.data[EVEN_SWING_BIT]);
	endproperty
	a_even_swing: assert property (p_even_swing) else $error("even swing not taken from write");

	property p_odd_swing;
		@(posedge CLK) disable iff (!NRST)
		ODD_DRIVE.swing_low == level[ODD_SWING_BIT];
	endproperty
	a_odd_swing: assert property (p_odd_swing) else $error("odd swing mismatch");

	property p_even_cm;
		@(posedge CLK) disable iff (!NRST)
		EVEN_DRIVE.cm == ((level[EVEN_CM_LSB +: 2] == CM_NA) ? CM_1V2 : level[EVEN_CM_LSB +: 2]);
	endproperty
	a_even_cm: assert property (p_even_cm) else $error("even common-mode mismatch");

	property p_odd_cm;
		@(posedge CLK) disable iff (!NRST)
		ODD_DRIVE.cm == ((level[ODD_CM_LSB +: 2] == CM_NA) ? CM_1V2 : level[ODD_CM_LSB +: 2]);
	endproperty
	a_odd_cm: assert property (p_odd_cm) else $error("odd common-mode mismatch");

	property p_even_dis;
		@(posedge CLK) disable iff (!NRST)
		(EVEN_BANK_OUTPUTS_EN & even_dis[4:0]) == '0 && even_dis[7:5] == 3'h0;
	endproperty
	a_even_dis: assert property (p_even_dis) else $error("disabled even channel active");

	property p_odd_dis;
		@(posedge CLK) disable iff (!NRST)
		(ODD_BANK_OUTPUTS_EN & odd_dis[4:0]) == '0 && odd_dis[7:5] == 3'h0;
	endproperty
	a_odd_dis: assert property (p_odd_dis) else $error("disabled odd channel active");

	property p_noclk_mode;
		@(posedge CLK) disable iff (!NRST)
		CE && !POWER_DOWN_INPUT && mode == MODE_NOCLK |=> OUTPUTS_AVAILABLE == $past(NO_CLK);
	endproperty
	a_noclk_mode: assert property (p_noclk_mode) else $error("clock-absent mode does not follow input");

	property p_pll_mode;
		@(posedge CLK) disable iff (!NRST)
		CE && mode == MODE_PLL && !STROBES_ALIGNED |=> !OUTPUTS_AVAILABLE;
	endproperty
	a_pll_mode: assert property (p_pll_mode) else $error("outputs enabled without strobe alignment");

	property p_2k_mode;
		@(posedge CLK) disable iff (!NRST)
		CE && mode == MODE_2K && cnt < CNT_2K - 12'h001 |=> !OUTPUTS_AVAILABLE;
	endproperty
	a_2k_mode: assert property (p_2k_mode) else $error("outputs enabled before 2K clocks");

	property p_1k_mode;
		@(posedge CLK) disable iff (!NRST)
		CE && !POWER_DOWN_INPUT && !NO_CLK && mode == MODE_DEFAULT && !avail_ctl[WAIT_SIZE_BIT] && cnt >= CNT_1K
		|=> OUTPUTS_AVAILABLE;
	endproperty
	a_1k_mode: assert property (p_1k_mode) else $error("outputs not enabled after 1K clocks");

	property p_wait_size;
		@(posedge CLK) disable iff (!NRST)
		CE && mode == MODE_DEFAULT && avail_ctl[WAIT_SIZE_BIT] && cnt < CNT_2K - 12'h001 |=> !OUTPUTS_AVAILABLE
		&& avail_ctl[4:0] == 5'h00;
	endproperty
	a_wait_size: assert property (p_wait_size) else $error("wait size ignored");

	property p_power_down;
		@(posedge CLK) disable iff (!NRST)
		CE && POWER_DOWN_INPUT |=> level == REG_RESET && even_dis == REG_RESET && odd_dis == REG_RESET
		&& avail_ctl == REG_RESET && !OUTPUTS_AVAILABLE;
	endproperty
	a_power_down: assert property (p_power_down) else $error("power-down did not clear");

	property p_gate;
		@(posedge CLK) disable iff (!NRST)
		(|EVEN_BANK_OUTPUTS_EN || |ODD_BANK_OUTPUTS_EN || CLOCK_CHANNEL_EN) |-> OUTPUTS_AVAILABLE;
	endproperty
	a_gate: assert property (p_gate) else $error("channel active before availability");
endmodule
`default_nettype wire

// ---- verification/two_wire_host.sv ----
// Purpose: two-wire serial host that programs and reads the output configuration registers
// Assumes: open-drain line resolved outside, sda is the wired level with pull-up
// Notes: every signal moves just after a rising clk edge; HALF sets the speed of each scl phase
`timescale 1ns/1ps
`default_nettype none
module two_wire_host #(
	parameter int HALF = 5
) (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic phase();
		repeat (HALF) @(posedge clk);
	endtask

	// also serves as repeated start from scl low
	task automatic start();
		@(posedge clk);
		sda_low <= 1'b0;
		phase();
		scl <= 1'b1;
		phase();
		sda_low <= 1'b1;
		phase();
		scl <= 1'b0;
		phase();
	endtask

	task automatic stop();
		sda_low <= 1'b1;
		phase();
		scl <= 1'b1;
		phase();
		sda_low <= 1'b0;
		phase();
	endtask

	// data only changes while scl is low
	task automatic one_bit(input logic b, output logic r);
		sda_low <= ~b;
		phase();
		scl <= 1'b1;
		phase();
		r = sda;
		scl <= 1'b0;
		phase();
	endtask

	// msb first, ninth bit released so the device may acknowledge
	task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack_n);
		for (int i = 7; i >= 0; i--) begin
			one_bit(d[i], r[i]);
		end
		one_bit(1'b1, ack_n);
	endtask

	task automatic write_reg(input logic [6:0] dev, input logic [7:0] addr, input logic [7:0] data,
		output logic ok);
		logic [7:0] r;
		logic a0;
		logic a1;
		logic a2;
		start();
		xfer({dev, 1'b0}, r, a0);
		xfer(addr, r, a1);
		xfer(data, r, a2);
		stop();
		ok = ~(a0 | a1 | a2);
	endtask

	// single byte read ended by a not-acknowledge from the host
	task automatic read_reg(input logic [6:0] dev, input logic [7:0] addr, output logic [7:0] data,
		output logic ok);
		logic [7:0] r;
		logic a0;
		logic a1;
		logic a2;
		logic a3;
		start();
		xfer({dev, 1'b0}, r, a0);
		xfer(addr, r, a1);
		start();
		xfer({dev, 1'b1}, r, a2);
		xfer(8'hff, data, a3);
		stop();
		ok = ~(a0 | a1 | a2);
	endtask
endmodule
`default_nettype wire

// ---- verification/lvds_tx_output_config_tb_top.sv ----
// Purpose: self-checking bench of the output configuration bank
// Assumes: serial host model on the register port, pixel ticks and clock status driven here
// Notes: expected values are derived from the register coding, never from the outputs
`timescale 1ns/1ps
`default_nettype none
module lvds_tx_output_config_tb_top
	import lvds_cfg_pkg::*;
;
	logic CLK = 1'b0;
	logic NRST = 1'b0;
	logic CE = 1'b1;
	logic POWER_DOWN_INPUT = 1'b0;
	logic INPUT_PIXEL_CLOCK_TICK = 1'b0;
	logic NO_CLK = 1'b0;
	logic STROBES_ALIGNED = 1'b0;
	logic SDA_OUT;
	logic SDA_OE;
	logic scl;
	logic host_low;
	wire logic sda_line;
	logic [NUM_CHANNELS-1:0] EVEN_BANK_OUTPUTS_EN;
	logic [NUM_CHANNELS-1:0] ODD_BANK_OUTPUTS_EN;
	logic CLOCK_CHANNEL_EN;
	drive_s EVEN_DRIVE;
	drive_s ODD_DRIVE;
	drive_s CLOCK_DRIVE;
	logic OUTPUTS_AVAILABLE;
	int n_errors = 0;
	int compares = 0;
	logic [7:0] lv[4] = '{8'hb6, 8'h68, 8'hff, 8'h05};
	logic [7:0] msk[4] = '{8'hff, 8'h1f, 8'h1f, 8'he0};
	logic [7:0] modes[3] = '{8'h00, 8'h40, 8'h20};
	int cnt[3] = '{1024, 2048, 2048};

	// open-drain line with pull-up
	assign sda_line = ~(host_low | SDA_OE);

	always #5 CLK = ~CLK;

	lvds_tx_output_config lvds_tx_output_config_i (
		.CLK(CLK),
		.NRST(NRST),
		.CE(CE),
		.POWER_DOWN_INPUT(POWER_DOWN_INPUT),
		.SCL(scl),
		.SDA_IN(sda_line),
		.SDA_OUT(SDA_OUT),
		.SDA_OE(SDA_OE),
		.INPUT_PIXEL_CLOCK_TICK(INPUT_PIXEL_CLOCK_TICK),
		.NO_CLK(NO_CLK),
		.STROBES_ALIGNED(STROBES_ALIGNED),
		.EVEN_BANK_OUTPUTS_EN(EVEN_BANK_OUTPUTS_EN),
		.ODD_BANK_OUTPUTS_EN(ODD_BANK_OUTPUTS_EN),
		.CLOCK_CHANNEL_EN(CLOCK_CHANNEL_EN),
		.EVEN_DRIVE(EVEN_DRIVE),
		.ODD_DRIVE(ODD_DRIVE),
		.CLOCK_DRIVE(CLOCK_DRIVE),
		.OUTPUTS_AVAILABLE(OUTPUTS_AVAILABLE)
	);

	two_wire_host two_wire_host_i (
		.clk(CLK),
		.sda(sda_line),
		.scl(scl),
		.sda_low(host_low)
	);

	task automatic finish_test();
		if (n_errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		logic ok;
		two_wire_host_i.write_reg(SLAVE_ADDR_DEFAULT, addr, data, ok);
		check({7'h0, ok}, 8'h01, "write ack");
	endtask

	task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
		logic ok;
		logic [7:0] d;
		two_wire_host_i.read_reg(SLAVE_ADDR_DEFAULT, addr, d, ok);
		check({7'h0, ok}, 8'h01, "read ack");
		check(d, exp, "read data");
	endtask

	function automatic drive_s lvl(input logic sw, input logic [1:0] cm);
		lvl.swing_low = sw;
		lvl.cm = (cm == CM_NA) ? CM_1V2 : cm;
	endfunction

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge CLK);
			INPUT_PIXEL_CLOCK_TICK <= 1'b1;
			@(posedge CLK);
			INPUT_PIXEL_CLOCK_TICK <= 1'b0;
		end
		#1;
	endtask

	task automatic edges(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask

	task automatic clear_count();
		@(posedge CLK);
		NO_CLK <= 1'b1;
		repeat (2) @(posedge CLK);
		NO_CLK <= 1'b0;
		edges(1);
	endtask

	// even disables 05, odd disables 1a
	task automatic avail(input logic on);
		check({7'h0, OUTPUTS_AVAILABLE}, {7'h0, on}, "available");
		check({7'h0, CLOCK_CHANNEL_EN}, {7'h0, on}, "clock channel");
		check({3'h0, EVEN_BANK_OUTPUTS_EN}, on ? 8'h1a : 8'h00, "even enables");
		check({3'h0, ODD_BANK_OUTPUTS_EN}, on ? 8'h05 : 8'h00, "odd enables");
	endtask

	initial begin
		repeat (80000) @(posedge CLK);
		n_errors++;
		$display("mismatch at %0t: run did not complete", $time);
		finish_test();
	end

	initial begin
		logic ok;
		repeat (4) @(posedge CLK);
		NRST <= 1'b1;
		edges(2);
		avail(1'b0);
		check({5'h0, CLOCK_DRIVE}, 8'h00, "clock drive after reset");
		check({6'h0, SDA_OE, SDA_OUT}, 8'h00, "serial pins idle");
		for (int i = 0; i < 4; i++) begin
			rd(ADDR_LEVEL + 8'(i), 8'h00);
		end
		rd(8'h20, 8'h00);
		two_wire_host_i.write_reg(7'h3b, ADDR_LEVEL, 8'hff, ok);
		check({7'h0, ok}, 8'h00, "foreign address ack");
		rd(ADDR_LEVEL, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_LEVEL + 8'(i), 8'hff);
			rd(ADDR_LEVEL + 8'(i), msk[i]);
		end
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_LEVEL, lv[i]);
			rd(ADDR_LEVEL, lv[i]);
			check(8'(EVEN_DRIVE), 8'(lvl(lv[i][5], lv[i][3:2])), "even drive");
			check(8'(ODD_DRIVE), 8'(lvl(lv[i][4], lv[i][1:0])), "odd drive");
			check(8'(CLOCK_DRIVE), 8'(lvl(lv[i][7] ? lv[i][4] : lv[i][5],
				lv[i][6] ? lv[i][1:0] : lv[i][3:2])), "clock drive");
		end
		wr(ADDR_EVEN_DIS, 8'h05);
		wr(ADDR_ODD_DIS, 8'h1a);
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_AVAIL, modes[i]);
			clear_count();
			tick(cnt[i] - 1);
			avail(1'b0);
			tick(1);
			avail(1'b1);
		end
		wr(ADDR_AVAIL, 8'h80);
		clear_count();
		tick(1024);
		avail(1'b0);
		@(posedge CLK);
		STROBES_ALIGNED <= 1'b1;
		edges(2);
		avail(1'b1);
		wr(ADDR_AVAIL, 8'hc0);
		clear_count();
		avail(1'b0);
		@(posedge CLK);
		STROBES_ALIGNED <= 1'b0;
		NO_CLK <= 1'b1;
		edges(2);
		avail(1'b1);
		@(posedge CLK);
		NO_CLK <= 1'b0;
		edges(2);
		avail(1'b0);
		wr(ADDR_AVAIL, 8'h00);
		tick(1023);
		// clock enable low: the last tick must be ignored
		@(posedge CLK);
		CE <= 1'b0;
		tick(1);
		avail(1'b0);
		@(posedge CLK);
		CE <= 1'b1;
		tick(1);
		avail(1'b1);
		@(posedge CLK);
		POWER_DOWN_INPUT <= 1'b1;
		edges(2);
		avail(1'b0);
		check(8'(EVEN_DRIVE), 8'h00, "even drive cleared");
		@(posedge CLK);
		POWER_DOWN_INPUT <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			rd(ADDR_LEVEL + 8'(i), 8'h00);
		end
		finish_test();
	end
endmodule
`default_nettype wire
